/* File: inc/stepper_cfg.svh */
// stepper_cfg.svh: offsets, field positions, reset values and timing figures
// assumes inclusion by bare name from the package and the design modules
`ifndef STEPPER_CFG_SVH
`define STEPPER_CFG_SVH

// clock and frame
`define CLK_PERIOD_NS  100
`define FRAME_LAST     5'h0f
`define FRAME_DONE     5'h10
`define HDR_LAST       5'h03
`define DATA_BITS      12
`define REG_COUNT      7
`define ADDR_LIMIT     3'h7

// register addresses
`define ADDR_CTRL      3'h0
`define ADDR_CURRENT_SCALE_AND_SAMPLING    3'h1
`define ADDR_OFF       3'h2
`define ADDR_BLANK     3'h3
`define ADDR_DECAY     3'h4
`define ADDR_STALL     3'h5
`define ADDR_DRIVE     3'h6

// reset values
`define RST_CTRL       12'h0c10
`define RST_CURRENT_SCALE_AND_SAMPLING     12'h01ff
`define RST_OFF        12'h0030
`define RST_BLANK      12'h0080
`define RST_DECAY      12'h0110
`define RST_STALL      12'h0040
`define RST_DRIVE      12'h0a59

// bits that hold state, and bits that read back
`define WM_CTRL        12'h0ffb
`define WM_CURRENT_SCALE_AND_SAMPLING      12'h07ff
`define WM_OFF         12'h01ff
`define WM_BLANK       12'h01ff
`define WM_DECAY       12'h07ff
`define WM_STALL       12'h0fff
`define WM_DRIVE       12'h0fff
`define RM_CURRENT_SCALE_AND_SAMPLING      12'h03ff

// field positions
`define F_ENABLE       0
`define F_REVERSE      1
`define F_ADVANCE      2
`define F_RES_HI       6
`define F_RES_LO       3
`define F_EXT_STALL    7
`define F_GAIN_HI      9
`define F_GAIN_LO      8
`define F_DEAD_HI      11
`define F_DEAD_LO      10
`define F_BYTE_HI      7
`define F_BYTE_LO      0
`define F_SMPL_HI      10
`define F_SMPL_LO      8
`define F_BYPASS       8
`define F_ADAPTIVE     8
`define F_DECAY_HI     10
`define F_DECAY_LO     8
`define F_SCNT_HI      9
`define F_SCNT_LO      8
`define F_BEMF_DIVIDER_HI      11
`define F_BEMF_DIVIDER_LO      10
`define F_OCTH_HI      1
`define F_OCTH_LO      0
`define F_OCDG_HI      3
`define F_OCDG_LO      2
`define F_TLOW_HI      5
`define F_TLOW_LO      4
`define F_THIGH_HI     7
`define F_THIGH_LO     6
`define F_ILOW_HI      9
`define F_ILOW_LO      8
`define F_IHIGH_HI     11
`define F_IHIGH_LO     10

// codes
`define RES_LAST       4'h8
`define DEC_SLOW       3'h0
`define DEC_SLOW_MIX   3'h1
`define DEC_FAST       3'h2
`define DEC_MIXED      3'h3
`define DEC_SLOW_AUTO  3'h4
`define DEC_AUTO       3'h5
`define BLANK_MIN      8'h32

// timing and scale figures
`define DEAD0_NS       400
`define DEAD1_NS       450
`define DEAD2_NS       650
`define DEAD3_NS       850
`define OFF_STEP_NS    500
`define MIX_STEP_NS    500
`define DEGLITCH_NS    1000
`define SMPL0_US       11'h032
`define SMPL1_US       11'h064
`define SMPL2_US       11'h0c8
`define SMPL3_US       11'h12c
`define SMPL4_US       11'h190
`define SMPL5_US       11'h258
`define SMPL6_US       11'h320
`define SMPL7_US       11'h3e8
`define GAIN_BASE      6'h05
`define BEMF_DIVIDER_MAX_LOG2  3'h5
`define OCTH_STEP_MV   10'h0fa
`define GATE_BASE_NS   11'h0fa
`define ILOW_STEP_MA   9'h064
`define IHIGH_STEP_MA  8'h32
`define CEIL_CYC(t, p) (((t) + (p) - 1) / (p))

`endif

/* File: inc/stepper_pkg.sv */
// stepper_pkg: types shared by the configuration bank and its users
// assumes stepper_cfg.svh on the include path
`default_nettype none
`include "stepper_cfg.svh"
package stepper_pkg;

   typedef enum logic [1:0] {DECAY_SLOW, DECAY_FAST, DECAY_MIXED, DECAY_AUTO} decay_e;

   typedef logic [`DATA_BITS-1:0] reg_word_t;

   typedef struct packed {
      logic serial_select_pin;
      logic serial_clock_pin;
      logic serial_in_pin;
   } serial_in_s;

   typedef struct packed {
      logic [3:0]  step_res_log2;
      logic        step_res_valid;
      logic        stall_external;
      logic [5:0]  sense_amp_gain;
      logic [5:0]  dead_cycles;
      logic [7:0]  current_scale;
      logic [10:0] sample_thr_us;
      logic [12:0] off_cycles;
      logic [7:0]  blank_units;
      logic        adaptive_blank_enable;
      logic [12:0] mixed_decay_cycles;
      decay_e      decay_mode;
      logic [7:0]  stall_threshold;
      logic [2:0]  bemf_div_log2;
      logic [9:0]  oc_threshold_mv;
      logic [10:0] low_gate_drive_ns;
      logic [10:0] high_gate_drive_ns;
      logic [8:0]  low_gate_peak_ma;
      logic [7:0]  high_gate_peak_ma;
   } motor_cfg_s;

   typedef struct packed {
      reg_word_t [`REG_COUNT-1:0] regs;
      logic                       sclk_q;
      logic [4:0]                 bit_cnt;
      logic [14:0]                shift;
      logic                       rd;
      reg_word_t                  rdat;
      logic                       sdo;
      logic                       advance;
      logic [3:0]                 stall_cnt;
      logic                       stall;
      logic [11:0]                oc_cnt;
      logic                       oc_event;
   } bank_state_s;

endpackage : stepper_pkg
`default_nettype wire

/* File: src/pin_filter.sv */
// pin_filter: three-stage sampler for pins from outside the clk domain
// assumes pins may change at any time; a change counts once stages two and three agree
`default_nettype none
module pin_filter #(
   parameter int          WIDTH       = 1,
   parameter logic [31:0] RESET_LEVEL = 32'h0000_0000
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // pins and filtered levels
   input  wire logic [WIDTH-1:0] pin_raw,
   output logic      [WIDTH-1:0] level
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] level;
   } filt_state_s;

   localparam filt_state_s ST_RESET = '{
      s1: RESET_LEVEL[WIDTH-1:0], s2: RESET_LEVEL[WIDTH-1:0],
      s3: RESET_LEVEL[WIDTH-1:0], level: RESET_LEVEL[WIDTH-1:0]};

   filt_state_s st_reg;
   filt_state_s st_next;

   if (WIDTH < 1 || WIDTH > 32) begin : g_check
      $error("pin_filter width out of range");
   end

   always_comb begin
      st_next       = st_reg;
      st_next.s1    = pin_raw;
      st_next.s2    = st_reg.s1;
      st_next.s3    = st_reg.s2;
      // per bit: take stage three where two and three agree
      st_next.level = (st_reg.s3 & ~(st_reg.s2 ^ st_reg.s3))
                    | (st_reg.level & (st_reg.s2 ^ st_reg.s3));
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign level = st_reg.level;

endmodule : pin_filter
`default_nettype wire

/* File: src/stepper_driver_config_regs.sv */
// stepper_driver_config_regs: serial-programmed configuration bank of the predriver
// assumes host frames of 16 link clocks under select; stall and overcurrent
// comparators, indexer and bridge logic share clk
//
// Operation
// - motor enable 0 keeps the power stage off; 1 enables drive
// - reverse heading 0 passes direction pin; 1 inverts it
// - writing 1 to bit 2 advances indexer one step; self-clearing, 0 ignored
// - 4-bit resolution code: full step up to 1/256; codes above 1000 reserved
// - stall source bit 7 picks internal (0) or external (1) stall detection
// - sense gain codes 00..11 give 5, 10, 20, 40
// - dead time codes give 400, 450, 650, 850 ns; default 11
// - 8-bit current scale for both bridges; resets to maximum
// - sample threshold codes give 50..1000 us; default 100 us
// - current scale register bit 10 is write-only and reads zero
// - off time is (code+1) times 500 ns
// - bypass bit 8 drives bridges from input pins, else from the indexer
// - blanking in 20 ns steps, codes up to 0x32 give 1 us
// - adaptive blanking bit 8 enables adaptive blanking
// - mixed decay transition time in 500 ns steps; default 0x10
// - decay codes: slow, fast, mixed, auto; 110 and 111 reserved
// - codes 001 and 100 slow on rise, mixed or auto on fall, indexer only
// - stall asserted after 1, 2, 4 or 8 steps below threshold
// - back EMF divider codes give 1/32, 1/16, 1/8, 1/4
// - overcurrent counts only after the deglitch time of 1 to 8 us
// - gate drive times 250 ns to 2 us; default 01
// - gate peak currents: sink 100..400 mA, source 50..200 mA
// - frame is 16 bits: rw, 3 address, 12 data; select held high
// - reads use address only, ignore data bits, answer on serial out
// - reset loads every register with its default fields
`default_nettype none
`include "stepper_cfg.svh"
module stepper_driver_config_regs
   import stepper_pkg::*;
#(
   parameter int CLK_NS = `CLK_PERIOD_NS
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // serial link
   input  wire serial_in_s serial_pins,
   output logic            serial_out_pin,
   // motor pins
   input  wire logic       dir_pin,
   input  wire logic [3:0] bridge_input_pins,
   // on-chip motor logic
   input  wire logic [3:0] indexer_drive,
   input  wire logic       current_rising,
   input  wire logic       bemf_step,
   input  wire logic       bemf_below,
   input  wire logic       bemf_valid_n,
   input  wire logic       oc_over,
   // controls
   output logic            power_stage_en,
   output logic            heading,
   output logic            advance_pulse,
   output logic [3:0]      bridge_drive,
   output logic            stall_out_pin_n,
   output logic            oc_event,
   output motor_cfg_s      cfg
);

   localparam int DEAD0_CYC = `CEIL_CYC(`DEAD0_NS, CLK_NS);
   localparam int DEAD1_CYC = `CEIL_CYC(`DEAD1_NS, CLK_NS);
   localparam int DEAD2_CYC = `CEIL_CYC(`DEAD2_NS, CLK_NS);
   localparam int DEAD3_CYC = `CEIL_CYC(`DEAD3_NS, CLK_NS);
   localparam int OFF_CYC   = `CEIL_CYC(`OFF_STEP_NS, CLK_NS);
   localparam int MIX_CYC   = `CEIL_CYC(`MIX_STEP_NS, CLK_NS);
   localparam int DEG_CYC   = `CEIL_CYC(`DEGLITCH_NS, CLK_NS);

   localparam reg_word_t [`REG_COUNT-1:0] WMASK = {
      `WM_DRIVE, `WM_STALL, `WM_DECAY, `WM_BLANK, `WM_OFF, `WM_CURRENT_SCALE_AND_SAMPLING, `WM_CTRL};
   localparam reg_word_t [`REG_COUNT-1:0] RMASK = {
      `WM_DRIVE, `WM_STALL, `WM_DECAY, `WM_BLANK, `WM_OFF, `RM_CURRENT_SCALE_AND_SAMPLING, `WM_CTRL};
   localparam bank_state_s ST_RESET = '{
      regs: {`RST_DRIVE, `RST_STALL, `RST_DECAY, `RST_BLANK,
             `RST_OFF, `RST_CURRENT_SCALE_AND_SAMPLING, `RST_CTRL},
      default: '0};

   if (CLK_NS < 20 || CLK_NS > 400) begin : g_check
      $error("clock period outside what the timing counts can serve");
   end

   bank_state_s st_reg;
   bank_state_s st_next;
   logic [2:0]  ser_lvl;
   logic [4:0]  pin_lvl;
   logic        sel_f;
   logic        sclk_f;
   logic        sdi_f;
   logic        take_bit;
   logic        hdr_load;
   logic [2:0]  hdr_addr;
   reg_word_t   read_word;
   logic [15:0] frame_word;
   logic        wr_commit;
   logic [2:0]  wr_addr;
   reg_word_t   wr_data;
   logic [3:0]  stall_steps;
   logic [11:0] oc_lim;
   reg_word_t   ctrl;
   reg_word_t   current_scale_and_sampling;
   reg_word_t   offr;
   reg_word_t   blank;
   reg_word_t   decay;
   reg_word_t   stall;
   reg_word_t   drive;

   // pins from the host and the board
   pin_filter #(
      .WIDTH       (3),
      .RESET_LEVEL (32'h0000_0000)
   ) u_serial_filter (
      .clk     (clk),
      .resetn  (resetn),
      .pin_raw (serial_pins),
      .level   (ser_lvl)
   );

   pin_filter #(
      .WIDTH       (5),
      .RESET_LEVEL (32'h0000_0000)
   ) u_motor_filter (
      .clk     (clk),
      .resetn  (resetn),
      .pin_raw ({dir_pin, bridge_input_pins}),
      .level   (pin_lvl)
   );

   assign sel_f  = ser_lvl[2];
   assign sclk_f = ser_lvl[1];
   assign sdi_f  = ser_lvl[0];

   assign ctrl   = st_reg.regs[`ADDR_CTRL];
   assign current_scale_and_sampling = st_reg.regs[`ADDR_CURRENT_SCALE_AND_SAMPLING];
   assign offr   = st_reg.regs[`ADDR_OFF];
   assign blank  = st_reg.regs[`ADDR_BLANK];
   assign decay  = st_reg.regs[`ADDR_DECAY];
   assign stall  = st_reg.regs[`ADDR_STALL];
   assign drive  = st_reg.regs[`ADDR_DRIVE];

   // frame decode
   assign take_bit   = sel_f & sclk_f & ~st_reg.sclk_q
                     & (st_reg.bit_cnt < `FRAME_DONE);
   assign frame_word = {st_reg.shift, sdi_f};
   assign hdr_load   = take_bit & (st_reg.bit_cnt == `HDR_LAST);
   assign hdr_addr   = frame_word[2:0];
   assign read_word  = (hdr_addr < `ADDR_LIMIT)
                     ? (st_reg.regs[hdr_addr] & RMASK[hdr_addr])
                     : '0;
   assign wr_addr    = frame_word[14:12];
   assign wr_data    = frame_word[11:0];
   assign wr_commit  = take_bit & (st_reg.bit_cnt == `FRAME_LAST)
                     & ~st_reg.rd & (wr_addr < `ADDR_LIMIT);

   assign stall_steps = 4'(4'h1 << stall[`F_SCNT_HI:`F_SCNT_LO]);
   assign oc_lim      = 12'(DEG_CYC << drive[`F_OCDG_HI:`F_OCDG_LO]);

   always_comb begin
      st_next         = st_reg;
      st_next.advance = 1'b0;
      st_next.sclk_q  = sclk_f;
      // serial frame
      if (!sel_f) begin
         st_next.bit_cnt = '0;
         st_next.rd      = 1'b0;
         st_next.sdo     = 1'b0;
      end else if (take_bit) begin
         st_next.shift   = frame_word[14:0];
         st_next.bit_cnt = 5'(st_reg.bit_cnt + 5'h01);
         if (hdr_load) begin
            st_next.rd   = frame_word[3];
            st_next.sdo  = frame_word[3] & read_word[`DATA_BITS-1];
            st_next.rdat = {read_word[`DATA_BITS-2:0], 1'b0};
         end else if (st_reg.rd && st_reg.bit_cnt < `FRAME_LAST) begin
            st_next.sdo  = st_reg.rdat[`DATA_BITS-1];
            st_next.rdat = {st_reg.rdat[`DATA_BITS-2:0], 1'b0};
         end else begin
            st_next.sdo  = 1'b0;
         end
         if (wr_commit) begin
            st_next.regs[wr_addr] = wr_data & WMASK[wr_addr];
            if (wr_addr == `ADDR_CTRL) begin
               st_next.advance = wr_data[`F_ADVANCE];
            end
         end
      end
      // internal stall counting
      if (ctrl[`F_EXT_STALL]) begin
         st_next.stall_cnt = '0;
         st_next.stall     = 1'b0;
      end else if (bemf_step) begin
         if (bemf_below) begin
            if (st_reg.stall_cnt < stall_steps) begin
               st_next.stall_cnt = 4'(st_reg.stall_cnt + 4'h1);
            end
            if (4'(st_reg.stall_cnt + 4'h1) >= stall_steps) begin
               st_next.stall = 1'b1;
            end
         end else begin
            st_next.stall_cnt = '0;
            st_next.stall     = 1'b0;
         end
      end
      // overcurrent deglitch
      if (oc_over) begin
         if (st_reg.oc_cnt <= oc_lim) begin
            st_next.oc_cnt = 12'(st_reg.oc_cnt + 12'h001);
         end
         st_next.oc_event = (st_reg.oc_cnt >= oc_lim);
      end else begin
         st_next.oc_cnt   = '0;
         st_next.oc_event = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // controls toward the power stage
   assign serial_out_pin  = st_reg.sdo;
   assign power_stage_en  = ctrl[`F_ENABLE];
   assign heading         = pin_lvl[4] ^ ctrl[`F_REVERSE];
   assign advance_pulse   = st_reg.advance;
   assign bridge_drive    = !ctrl[`F_ENABLE] ? 4'h0 :
                            offr[`F_BYPASS] ? pin_lvl[3:0] :
                            indexer_drive;
   assign stall_out_pin_n = ctrl[`F_EXT_STALL] ? bemf_valid_n
                                               : ~st_reg.stall;
   assign oc_event        = st_reg.oc_event;

   // decoded configuration
   always_comb begin
      cfg                = '0;
      cfg.step_res_log2  = ctrl[`F_RES_HI:`F_RES_LO];
      cfg.step_res_valid = (ctrl[`F_RES_HI:`F_RES_LO] <= `RES_LAST);
      cfg.stall_external = ctrl[`F_EXT_STALL];
      cfg.sense_amp_gain = 6'(`GAIN_BASE << ctrl[`F_GAIN_HI:`F_GAIN_LO]);
      case (ctrl[`F_DEAD_HI:`F_DEAD_LO])
         2'h0:    cfg.dead_cycles = 6'(DEAD0_CYC);
         2'h1:    cfg.dead_cycles = 6'(DEAD1_CYC);
         2'h2:    cfg.dead_cycles = 6'(DEAD2_CYC);
         default: cfg.dead_cycles = 6'(DEAD3_CYC);
      endcase
      cfg.current_scale = current_scale_and_sampling[`F_BYTE_HI:`F_BYTE_LO];
      case (current_scale_and_sampling[`F_SMPL_HI:`F_SMPL_LO])
         3'h0:    cfg.sample_thr_us = `SMPL0_US;
         3'h1:    cfg.sample_thr_us = `SMPL1_US;
         3'h2:    cfg.sample_thr_us = `SMPL2_US;
         3'h3:    cfg.sample_thr_us = `SMPL3_US;
         3'h4:    cfg.sample_thr_us = `SMPL4_US;
         3'h5:    cfg.sample_thr_us = `SMPL5_US;
         3'h6:    cfg.sample_thr_us = `SMPL6_US;
         default: cfg.sample_thr_us = `SMPL7_US;
      endcase
      cfg.off_cycles = 13'((32'(offr[`F_BYTE_HI:`F_BYTE_LO]) + 1) * OFF_CYC);
      cfg.blank_units = (blank[`F_BYTE_HI:`F_BYTE_LO] < `BLANK_MIN)
                      ? `BLANK_MIN : blank[`F_BYTE_HI:`F_BYTE_LO];
      cfg.adaptive_blank_enable = blank[`F_ADAPTIVE];
      cfg.mixed_decay_cycles = 13'(32'(decay[`F_BYTE_HI:`F_BYTE_LO]) * MIX_CYC);
      case (decay[`F_DECAY_HI:`F_DECAY_LO])
         `DEC_SLOW:      cfg.decay_mode = DECAY_SLOW;
         `DEC_FAST:      cfg.decay_mode = DECAY_FAST;
         `DEC_MIXED:     cfg.decay_mode = DECAY_MIXED;
         `DEC_AUTO:      cfg.decay_mode = DECAY_AUTO;
         `DEC_SLOW_MIX:  cfg.decay_mode = (offr[`F_BYPASS] || current_rising)
                                        ? DECAY_SLOW : DECAY_MIXED;
         `DEC_SLOW_AUTO: cfg.decay_mode = (offr[`F_BYPASS] || current_rising)
                                        ? DECAY_SLOW : DECAY_AUTO;
         default:        cfg.decay_mode = DECAY_SLOW;
      endcase
      cfg.stall_threshold = stall[`F_BYTE_HI:`F_BYTE_LO];
      cfg.bemf_div_log2 = 3'(`BEMF_DIVIDER_MAX_LOG2 - 3'(stall[`F_BEMF_DIVIDER_HI:`F_BEMF_DIVIDER_LO]));
      cfg.oc_threshold_mv = 10'((10'(drive[`F_OCTH_HI:`F_OCTH_LO]) + 10'h001)
                          * `OCTH_STEP_MV);
      cfg.low_gate_drive_ns  = 11'(`GATE_BASE_NS << drive[`F_TLOW_HI:`F_TLOW_LO]);
      cfg.high_gate_drive_ns = 11'(`GATE_BASE_NS << drive[`F_THIGH_HI:`F_THIGH_LO]);
      cfg.low_gate_peak_ma   = 9'((9'(drive[`F_ILOW_HI:`F_ILOW_LO]) + 9'h001)
                             * `ILOW_STEP_MA);
      cfg.high_gate_peak_ma  = 8'((8'(drive[`F_IHIGH_HI:`F_IHIGH_LO]) + 8'h01)
                             * `IHIGH_STEP_MA);
   end

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_write_ctrl;
      wr_commit && (wr_addr == `ADDR_CTRL);
   endsequence

   sequence s_read_current_scale_and_sampling_hdr;
      hdr_load && frame_word[3] && (hdr_addr == `ADDR_CURRENT_SCALE_AND_SAMPLING);
   endsequence

   sequence s_read_last_bit;
      take_bit && st_reg.rd && (st_reg.bit_cnt == `FRAME_LAST);
   endsequence

   AST_ENABLE_FOLLOWS: assert property (
      s_write_ctrl |=> (power_stage_en == $past(wr_data[`F_ENABLE]))
         && (power_stage_en || bridge_drive == 4'h0))
      else $error("motor enable did not follow the written value");

   AST_HEADING_INVERTS: assert property (
      ctrl[`F_REVERSE] |-> (heading != pin_lvl[4]))
      else $error("reversed heading not inverted");

   AST_ADVANCE_ONE: assert property (
      (s_write_ctrl ##0 wr_data[`F_ADVANCE]) |=> advance_pulse ##1 !advance_pulse
         && !ctrl[`F_ADVANCE])
      else $error("single advance not exactly one cycle");

   AST_CURRENT_SCALE_AND_SAMPLING_BIT10_ZERO: assert property (
      s_read_current_scale_and_sampling_hdr |=> !st_reg.sdo ##0 !st_reg.rdat[`DATA_BITS-1])
      else $error("write-only bit read back nonzero");

   AST_READ_KEEPS_REGS: assert property (
      s_read_last_bit |=> $stable(st_reg.regs))
      else $error("read frame changed a register");

   AST_FRAME_ABORT: assert property (
      $fell(sel_f) |=> (st_reg.bit_cnt == 5'h00) && !serial_out_pin)
      else $error("frame not dropped when select fell");

   AST_STALL_CAUSE: assert property (
      ($fell(stall_out_pin_n) && !ctrl[`F_EXT_STALL])
         |-> $past(bemf_step && bemf_below)
         && ($past(st_reg.stall_cnt) + 4'h1 >= $past(stall_steps)))
      else $error("stall asserted without enough low steps");

   AST_OC_DEGLITCH: assert property (
      $rose(oc_event) |-> $past(oc_over) && ($past(st_reg.oc_cnt) >= $past(oc_lim)))
      else $error("overcurrent recognised before deglitch time");

   AST_BYPASS_PINS: assert property (
      (ctrl[`F_ENABLE] && offr[`F_BYPASS]) |-> (bridge_drive == pin_lvl[3:0]))
      else $error("bypass mode not driving from bridge pins");

endmodule : stepper_driver_config_regs
`default_nettype wire

/* File: verification/stepper_host_model.sv */
// stepper_host_model: host master that frames 16-bit words on the serial link
// assumes clk at 100 ns; link clock of 800 ns, still outside frames
`default_nettype none
module stepper_host_model
   import stepper_pkg::*;
(
   // clock
   input  wire logic clk,
   // link
   output serial_in_s pins,
   input  wire logic  sdo
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pins = '0;
   // rw, address, data, msb first, select held throughout
   task automatic xfer(input logic [15:0] w, output logic [11:0] rd);
      rd = '0;
      @(posedge clk) #10;
      pins.serial_select_pin = 1'b1;
      for (int i = 15; i >= 0; i--) begin
         pins.serial_in_pin = w[i];
         repeat (4) @(posedge clk);
         #10 if (i < 12) rd[i] = sdo;
         pins.serial_clock_pin = 1'b1;
         repeat (4) @(posedge clk);
         #10 pins.serial_clock_pin = 1'b0;
      end
      repeat (4) @(posedge clk);
      #10 pins.serial_select_pin = 1'b0;
      // released data line shows the inverse of its last value
      pins.serial_in_pin = ~w[0];
      repeat (8) @(posedge clk);
      #10;
   endtask : xfer
endmodule : stepper_host_model
`default_nettype wire

/* File: verification/stepper_driver_config_regs_tb_top.sv */
// stepper_driver_config_regs_tb_top: register and control checks over the serial link
// assumes stepper_host_model and the package on the include path
`default_nettype none
module stepper_driver_config_regs_tb_top
   import stepper_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam reg_word_t DEF [8] = '{12'h0c10, 12'h01ff, 12'h0030, 12'h0080, 12'h0110,
                                     12'h0040, 12'h0a59, 12'h0000};
   localparam reg_word_t RBK [8] = '{12'h0ffb, 12'h03ff, 12'h01ff, 12'h01ff, 12'h07ff,
                                     12'h0fff, 12'h0fff, 12'h0000};
   logic       clk = 0, resetn = 0, dir_pin = 1, bemf_step = 0, bemf_below = 0, rise = 0;
   logic       bemf_valid_n = 1, oc_over = 0, sdo, pwr, head, adv, stall_n, oc;
   logic [3:0] bin = 4'h5, idx = 4'ha, bdrv;
   serial_in_s pins;
   motor_cfg_s cfg;
   reg_word_t  rd;
   int         mismatches = 0, checks = 0, pulses = 0;
   always #50 clk = ~clk;
   always @(posedge clk) if (adv === 1'b1) pulses++;
   stepper_driver_config_regs DUT (
      .clk(clk), .resetn(resetn), .serial_pins(pins), .serial_out_pin(sdo),
      .dir_pin(dir_pin), .bridge_input_pins(bin), .indexer_drive(idx),
      .current_rising(rise), .bemf_step(bemf_step), .bemf_below(bemf_below),
      .bemf_valid_n(bemf_valid_n), .oc_over(oc_over), .power_stage_en(pwr),
      .heading(head), .advance_pulse(adv), .bridge_drive(bdrv),
      .stall_out_pin_n(stall_n), .oc_event(oc), .cfg(cfg));
   stepper_host_model HOST (.clk(clk), .pins(pins), .sdo(sdo));
   task automatic cmp(input string n, input logic [11:0] e, input logic [11:0] s);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : cmp
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask : tick
   task automatic wr(input logic [2:0] a, input reg_word_t d);
      HOST.xfer({1'b0, a, d}, rd);
   endtask : wr
   // data bits of a read are nonzero and must be ignored
   task automatic rchk(input logic [2:0] a, input reg_word_t e);
      HOST.xfer({1'b1, a, 12'h05a5}, rd);
      cmp("read", e, rd);
   endtask : rchk
   task automatic step();
      bemf_step = 1;
      tick(1);
      bemf_step = 0;
      tick(1);
   endtask : step
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   initial begin
      tick(5);
      resetn = 1;
      tick(5);
      for (int a = 0; a < 8; a++) rchk(3'(a), DEF[a]);
      cmp("res", 12'h002, 12'(cfg.step_res_log2));
      cmp("gain", 12'h005, 12'(cfg.sense_amp_gain));
      cmp("dead", 12'h009, 12'(cfg.dead_cycles));
      cmp("scale", 12'h0ff, 12'(cfg.current_scale));
      cmp("sample", 12'h064, 12'(cfg.sample_thr_us));
      cmp("off", 12'h0f5, 12'(cfg.off_cycles));
      cmp("blank", 12'h080, 12'(cfg.blank_units));
      cmp("mix", 12'h050, 12'(cfg.mixed_decay_cycles));
      cmp("decay", 12'(DECAY_MIXED), 12'(cfg.decay_mode));
      cmp("stall_threshold", 12'h040, 12'(cfg.stall_threshold));
      cmp("bemf_divider", 12'h005, 12'(cfg.bemf_div_log2));
      cmp("octh", 12'h1f4, 12'(cfg.oc_threshold_mv));
      cmp("tdrv", 12'h1f4, 12'(cfg.low_gate_drive_ns));
      cmp("idrv", 12'h12c, 12'(cfg.low_gate_peak_ma));
      cmp("isrc", 12'h096, 12'(cfg.high_gate_peak_ma));
      $display("test defaults done");
      for (int a = 0; a < 8; a++) wr(3'(a), 12'hfff);
      for (int a = 0; a < 8; a++) rchk(3'(a), RBK[a]);
      cmp("pulses", 12'h001, 12'(pulses));
      cmp("enable", 12'h001, 12'(pwr));
      cmp("heading", 12'h000, 12'(head));
      cmp("bridge", 12'h005, 12'(bdrv));
      cmp("res ok", 12'h000, 12'(cfg.step_res_valid));
      cmp("stall src", 12'h001, 12'(cfg.stall_external));
      cmp("gain", 12'h028, 12'(cfg.sense_amp_gain));
      cmp("sample", 12'h3e8, 12'(cfg.sample_thr_us));
      cmp("off", 12'h500, 12'(cfg.off_cycles));
      cmp("adapt", 12'h001, 12'(cfg.adaptive_blank_enable));
      cmp("decay", 12'(DECAY_SLOW), 12'(cfg.decay_mode));
      cmp("bemf_divider", 12'h002, 12'(cfg.bemf_div_log2));
      cmp("tdrv", 12'h7d0, 12'(cfg.high_gate_drive_ns));
      cmp("isrc", 12'h0c8, 12'(cfg.high_gate_peak_ma));
      $display("test write all done");
      wr(3'h0, 12'h080);
      bemf_valid_n = 0;
      tick(6);
      cmp("ext stall", 12'h000, 12'(stall_n));
      bemf_valid_n = 1;
      wr(3'h0, 12'h003);
      cmp("pulses", 12'h001, 12'(pulses));
      wr(3'h2, 12'h000);
      cmp("bridge", 12'h00a, 12'(bdrv));
      wr(3'h4, 12'h100);
      cmp("decay", 12'(DECAY_MIXED), 12'(cfg.decay_mode));
      wr(3'h4, 12'h400);
      cmp("decay", 12'(DECAY_AUTO), 12'(cfg.decay_mode));
      rise = 1;
      tick(1);
      cmp("decay", 12'(DECAY_SLOW), 12'(cfg.decay_mode));
      wr(3'h4, 12'h200);
      cmp("decay", 12'(DECAY_FAST), 12'(cfg.decay_mode));
      rise = 0;
      wr(3'h3, 12'h010);
      cmp("blank", 12'h032, 12'(cfg.blank_units));
      cmp("adapt", 12'h000, 12'(cfg.adaptive_blank_enable));
      wr(3'h0, 12'h000);
      cmp("enable", 12'h000, 12'(pwr));
      cmp("heading", 12'h001, 12'(head));
      $display("test controls done");
      bemf_below = 1;
      repeat (7) step();
      cmp("stall early", 12'h001, 12'(stall_n));
      step();
      cmp("stall", 12'h000, 12'(stall_n));
      oc_over = 1;
      tick(75);
      cmp("oc early", 12'h000, 12'(oc));
      tick(15);
      cmp("oc", 12'h001, 12'(oc));
      oc_over = 0;
      tick(3);
      cmp("oc drop", 12'h000, 12'(oc));
      $display("test stall and overcurrent done");
      resetn = 0;
      tick(2);
      resetn = 1;
      tick(5);
      cmp("reset dead", 12'h009, 12'(cfg.dead_cycles));
      cmp("reset stall", 12'h001, 12'(stall_n));
      rchk(3'h5, 12'h040);
      rchk(3'h6, 12'ha59);
      $display("test reset done");
      summarize();
   end
   initial begin
      #2_000_000;
      mismatches++;
      summarize();
   end
endmodule : stepper_driver_config_regs_tb_top
`default_nettype wire
